// File: adi_host_model.sv
// adi_host_model: host side of the die, register strobes, power stage bit, interrupt count
// assumes the die samples req and power_stage_on_bit on the rising edge of ref_clk
`timescale 1ns/1ps
`default_nettype none
module adi_host_model
(
    // clock
    input  wire logic                 ref_clk,
    // register port and power stage bit
    output var  adi_pkg::adi_req_type req,
    input  wire logic [7:0]           rdData,
    output var  logic                 power_stage_on_bit,
    // interrupt line
    input  wire logic                 irqPulse
);
    import adi_pkg::*;
    int irqCount = 0;
    // idle port at time zero
    initial
    begin
        req = '0;
        power_stage_on_bit = 1'b0;
    end
    // one count per interrupt pulse
    always @(posedge ref_clk)
    begin
        if (irqPulse === 1'b1)
            irqCount <= irqCount + 1;
    end
    // one-cycle strobe; released fields show the inverse so stale data is never reused
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge ref_clk);
        #1 req = '{wr: w, rd: !w, addr: a, data: d};
        @(posedge ref_clk);
        #1 q = rdData;
        req = '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
    endtask : xfer
    // power stage on before the host draws its running current
    task automatic set_ps(input logic v);
        @(posedge ref_clk);
        #1 power_stage_on_bit = v;
    endtask : set_ps
endmodule : adi_host_model
`default_nettype wire

// File: adi_irq_wake_mux.sv
// adi_irq_wake_mux: event flags, interrupt pulse, low-power wake detection,
// bus receive indication and analog source / current source control
// assumes pin inputs are asynchronous, register port and mode come from ref_clk logic
`timescale 1ns/1ps
`default_nettype none

module adi_irq_wake_mux
(
    // clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  arst_n,
    // register port
    input  wire adi_pkg::adi_req_type  req,
    output var  logic [7:0]            rdData,
    // device state
    input  wire adi_pkg::adi_mode_type mode,
    input  wire adi_pkg::adi_hall_type hallMode,
    input  wire logic                  power_stage_on_bit,
    // analog pins and comparators
    input  wire adi_pkg::adi_pins_type pins,
    // to the host
    output var  logic                  irqPulse,
    output var  logic                  busRxd,
    output var  logic                  wakeStop,
    output var  logic                  wakeReset,
    // bus physical layer
    output var  logic                  busTxEnable,
    output var  logic                  busPullupOn,
    // analog controls
    output var  logic                  currentSourceOn,
    output var  logic [1:0]            currentLevel,
    output var  logic                  senseGainLow,
    output var  logic [3:0]            sourceSelect
);
    import adi_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    adi_pins_type pinMeta;
    adi_pins_type pinSync;
    adi_pins_type pinPrev;
    logic [7:0]   imr;
    logic [7:0]   ifr;
    logic [7:0]   muxCtl;
    logic [1:0]   reset_status_register;
    logic         hallOcFlag;
    logic         wakeLatched;
    logic         lowPrev;
    logic [11:0]  domCnt;
    logic         isRun;
    logic         isStop;
    logic         isSleep;
    logic         longDom;
    logic         busRise;
    logic [7:0]   setVec;
    logic [7:0]   clrVec;
    logic [7:0]   next_ifr;
    logic         wakeChange;

    assign isRun   = (mode == MODE_RUN);
    assign isStop  = (mode == MODE_STOP);
    assign isSleep = (mode == MODE_SLEEP);

    // ------------------------------------------------------------
    // pin synchronisers and edge history
    // ------------------------------------------------------------
    // two flops before any logic looks at a pin
    // reset to idle levels, bus recessive, so no false bus edge follows reset
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pinMeta <= '{busIn: 1'b1, default: 1'b0};
            pinSync <= '{busIn: 1'b1, default: 1'b0};
            pinPrev <= '{busIn: 1'b1, default: 1'b0};
        end
        else
        begin
            pinMeta <= pins;
            pinSync <= pinMeta;
            pinPrev <= pinSync;
        end
    end

    // ------------------------------------------------------------
    // bus dominant timer
    // ------------------------------------------------------------
    // counts dominant cycles, saturating at the wake threshold
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            domCnt <= '0;
        else if (pinSync.busIn)
            domCnt <= '0;
        else if (domCnt != WAKE_CNT)
            domCnt <= domCnt + 12'h001;
    end

    assign longDom = (domCnt == WAKE_CNT);
    assign busRise = pinSync.busIn & ~pinPrev.busIn;

    // wake level latch and change detection
    assign wakeChange = ~isRun & lowPrev & (pinSync.wakeIn != wakeLatched);

    // ------------------------------------------------------------
    // event set and clear vectors
    // ------------------------------------------------------------
    always_comb
    begin
        setVec = '0;
        setVec[B_HV]   = isRun & pinSync.supplyHigh & ~pinPrev.supplyHigh;
        setVec[B_LV]   = isRun & pinSync.supplyLow & ~pinPrev.supplyLow;
        setVec[B_HT]   = isRun & pinSync.overTemp & ~pinPrev.overTemp;
        setVec[B_PSF]  = isRun & pinSync.stageFail & ~pinPrev.stageFail;
        setVec[B_BUS]  = isStop & imr[B_BUS] & longDom & busRise;
        setVec[B_HALL] = isRun & (hallMode != HALL_3PIN)
                       & (pinSync.hallIn != pinPrev.hallIn);
        setVec[B_WAKE] = (isRun & (pinSync.wakeIn != pinPrev.wakeIn))
                       | (isStop & wakeChange);
        clrVec = (req.wr && req.addr == OFS_IFR) ? req.data : '0;
        next_ifr = ((ifr & ~clrVec) | setVec) & IRQ_MASK;
    end

    // ------------------------------------------------------------
    // flag register and interrupt pulse
    // ------------------------------------------------------------
    // write 1 clears a flag; a set in the same cycle wins
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            ifr <= RST_BYTE;
        else
            ifr <= next_ifr;
    end

    // one pulse per cycle in which any flag whose mask bit is on is newly set
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            irqPulse <= 1'b0;
        else
            irqPulse <= |(setVec & ~ifr & imr);
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    // mask register: everything masked after reset
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            imr <= RST_BYTE;
        else if (req.wr && req.addr == OFS_IMR)
            imr <= req.data;
    end

    // analog select and current source control
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            muxCtl <= RST_BYTE;
        else if (req.wr && req.addr == OFS_MUXCTL)
            muxCtl <= req.data;
    end

    // hall over-current flag: set in 2-pin mode, write 1 clears, set wins
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            hallOcFlag <= 1'b0;
        else if (hallMode == HALL_2PIN && pinSync.hallOc)
            hallOcFlag <= 1'b1;
        else if (req.wr && req.addr == OFS_HWSTAT && req.data[B_HOC])
            hallOcFlag <= 1'b0;
    end

    // wake level is stored on the way into a low-power mode
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            lowPrev     <= 1'b0;
            wakeLatched <= 1'b0;
        end
        else
        begin
            lowPrev <= ~isRun;
            // a seen change re-arms the latch, so each wake request is one pulse
            // and a held level does not keep requesting
            if (isRun || wakeChange)
                wakeLatched <= pinSync.wakeIn;
        end
    end

    // reset status: wake sources seen in Sleep
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            reset_status_register <= '0;
        else
        begin
            if (isSleep && longDom && busRise)
                reset_status_register[B_RBUS] <= 1'b1;
            else if (req.rd && req.addr == OFS_RSTAT)
                reset_status_register[B_RBUS] <= 1'b0;
            if (isSleep && wakeChange)
                reset_status_register[B_RWAK] <= 1'b1;
            else if (req.rd && req.addr == OFS_RSTAT)
                reset_status_register[B_RWAK] <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // wake requests
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wakeStop  <= 1'b0;
            wakeReset <= 1'b0;
        end
        else
        begin
            wakeStop  <= setVec[B_BUS] | (isStop & wakeChange & imr[B_WAKE]);
            wakeReset <= isSleep & ((longDom & busRise) | wakeChange);
        end
    end

    // ------------------------------------------------------------
    // bus physical layer and analog outputs
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            busRxd          <= 1'b1;
            busTxEnable     <= 1'b0;
            busPullupOn     <= 1'b0;
            currentSourceOn <= 1'b0;
            currentLevel    <= LVL_40;
            senseGainLow    <= 1'b0;
            sourceSelect    <= '0;
        end
        else
        begin
            busRxd          <= pinSync.busIn;
            busTxEnable     <= isRun;
            busPullupOn     <= isRun;
            currentSourceOn <= isRun & power_stage_on_bit & muxCtl[B_CSEN]
                             & (muxCtl[B_SSH:0] == SS_A0 || muxCtl[B_SSH:0] == SS_CAL);
            currentLevel    <= muxCtl[B_LVLH:B_LVLL];
            senseGainLow    <= muxCtl[B_GAIN];
            sourceSelect    <= muxCtl[B_SSH:0];
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            rdData <= RST_BYTE;
        else if (req.rd)
        begin
            unique case (req.addr)
                OFS_HWSTAT: rdData <= {5'h00, pinSync.wakeIn, hallOcFlag, pinSync.hallIn};
                OFS_MUXCTL: rdData <= muxCtl;
                OFS_IMR:    rdData <= imr;
                OFS_IFR:    rdData <= ifr;
                OFS_RSTAT:  rdData <= {6'h00, reset_status_register};
                default:    rdData <= RST_BYTE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    sequence busWakeSeq;
        longDom && busRise;
    endsequence

    supply_high_gate_a: assert property (!isRun |=> !$rose(ifr[B_HV]))
        else $error("supply-high flag set outside run");
    supply_low_gate_a: assert property (!isRun |=> !$rose(ifr[B_LV]))
        else $error("supply-low flag set outside run");
    irq_mask_a: assert property ($rose(ifr[B_HT]) && !$past(imr[B_HT]) && $past(ifr) == 8'h00
                                 |-> !irqPulse)
        else $error("masked over-temp raised interrupt");
    irq_pulse_a: assert property (irqPulse |=> !irqPulse or $changed(ifr))
        else $error("interrupt pulse held without new flag");
    flag_hold_a: assert property (ifr[B_PSF] && !(req.wr && req.addr == OFS_IFR) |=> ifr[B_PSF])
        else $error("fault flag lost without clear");
    bus_stop_wake_a: assert property ((isStop && imr[B_BUS]) and busWakeSeq |=> ifr[B_BUS] && wakeStop)
        else $error("stop bus wake missed");
    bus_sleep_wake_a: assert property (isSleep and busWakeSeq |=> reset_status_register[B_RBUS] && wakeReset)
        else $error("sleep bus wake missed");
    // a held wake level must not repeat the request every cycle
    wake_pulse_a: assert property (wakeStop |=> !wakeStop)
        else $error("stop wake request held");
    rxd_follow_a: assert property (busRxd == $past(pinSync.busIn))
        else $error("receive output does not follow bus");
    lowpwr_phy_a: assert property (!isRun |=> !busTxEnable && !busPullupOn)
        else $error("transmitter on in low power");
    cs_enable_a: assert property (currentSourceOn |-> $past(power_stage_on_bit && isRun && muxCtl[B_CSEN]))
        else $error("current source on without conditions");
    hall_event_a: assert property (hallMode == HALL_3PIN && isRun && !ifr[B_HALL] |=> !ifr[B_HALL])
        else $error("hall event in three-pin mode");
    hall_oc_a: assert property (hallMode == HALL_2PIN && pinSync.hallOc |=> hallOcFlag)
        else $error("hall over-current not flagged");

endmodule : adi_irq_wake_mux

`default_nettype wire

// File: adi_irq_wake_mux_bench.sv
// adi_irq_wake_mux_bench: self-checking bench of the event, wake and mux block
// assumes adi_pkg, adi_irq_wake_mux and adi_host_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module adi_irq_wake_mux_bench;
    import adi_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    typedef struct {logic [7:0] addr; logic [7:0] data; logic [7:0] rd;} adi_row_type;
    logic         ref_clk, arst_n, power_stage_on_bit, irqPulse, busRxd, wakeStop, wakeReset;
    logic         busTxEnable, busPullupOn, currentSourceOn, senseGainLow;
    logic [1:0]   currentLevel;
    logic [3:0]   sourceSelect;
    logic [7:0]   rdData, q;
    adi_req_type  req;
    adi_mode_type mode;
    adi_hall_type hallMode;
    adi_pins_type pins;
    int           mismatches = 0, checked = 0, cycles = 0, nStop = 0, nReset = 0, base;
    int           pinIdx [4] = '{4, 7, 6, 5};
    adi_row_type  rows [7] = '{'{OFS_MUXCTL, 8'h00, 8'h00}, '{OFS_MUXCTL, 8'h31, 8'h31},
        '{OFS_MUXCTL, 8'h52, 8'h52}, '{OFS_MUXCTL, 8'h73, 8'h73}, '{OFS_MUXCTL, 8'h04, 8'h04},
        '{8'h0c, 8'h5a, 8'h00}, '{OFS_IMR, 8'h2f, 8'h2f}};
    // ------------------------------------------------------------
    // design and host
    // ------------------------------------------------------------
    adi_irq_wake_mux u_dut
    (
        .ref_clk(ref_clk), .arst_n(arst_n), .req(req), .rdData(rdData), .mode(mode),
        .hallMode(hallMode), .power_stage_on_bit(power_stage_on_bit), .pins(pins), .irqPulse(irqPulse), .busRxd(busRxd),
        .wakeStop(wakeStop), .wakeReset(wakeReset), .busTxEnable(busTxEnable),
        .busPullupOn(busPullupOn), .currentSourceOn(currentSourceOn), .currentLevel(currentLevel),
        .senseGainLow(senseGainLow), .sourceSelect(sourceSelect)
    );
    adi_host_model u_host
    (
        .ref_clk(ref_clk), .req(req), .rdData(rdData), .power_stage_on_bit(power_stage_on_bit), .irqPulse(irqPulse)
    );
    // 40 MHz clock
    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    // wake pulse counters and hang limit
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (wakeStop === 1'b1)
            nStop <= nStop + 1;
        if (wakeReset === 1'b1)
            nReset <= nReset + 1;
        if (cycles == 20000)
        begin
            mismatches++;
            report_and_stop();
        end
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check_val(input logic [7:0] act, input logic [7:0] exp);
        checked++;
        if (act !== exp)
        begin
            mismatches++;
            $display("[FAIL] t=%0t got %h expected %h", $time, act, exp);
        end
    endtask : check_val
    task automatic check_cnt(input int act, input int exp);
        checked++;
        if (act != exp)
        begin
            mismatches++;
            $display("[FAIL] t=%0t count %h expected %h", $time, act, exp);
        end
    endtask : check_cnt
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_host.xfer(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        u_host.xfer(1'b0, a, 8'h00, q);
        check_val(q, exp);
    endtask : rd
    task automatic report_and_stop;
        if (mismatches == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        arst_n = 1'b0;
        mode = MODE_RUN;
        hallMode = HALL_GP;
        pins = adi_pins_type'(8'h01);
        cyc(10);
        check_val(8'(sourceSelect), 8'h00);
        check_val(8'(currentLevel), 8'(LVL_40));
        arst_n = 1'b1;
        cyc(3);
        check_val(8'(busRxd), 8'h01);
        rd(OFS_IMR, 8'h00);
        rd(OFS_MUXCTL, RST_BYTE);
        // register rows, field outputs follow the analog control byte
        foreach (rows[i])
        begin
            wr(rows[i].addr, rows[i].data);
            rd(rows[i].addr, rows[i].rd);
            if (rows[i].addr == OFS_MUXCTL)
            begin
                check_val(8'(currentLevel), 8'(rows[i].data[6:5]));
                check_val(8'(senseGainLow), 8'(rows[i].data[B_GAIN]));
                check_val(8'(sourceSelect), 8'(rows[i].data[3:0]));
            end
        end
        // second reset in mid-run clears the control byte
        wr(OFS_MUXCTL, 8'hff);
        arst_n = 1'b0;
        cyc(2);
        arst_n = 1'b1;
        cyc(3);
        rd(OFS_MUXCTL, 8'h00);
        // each comparator event masked, then enabled
        for (int i = 0; i < 4; i++)
        begin
            wr(OFS_IMR, 8'h00);
            base = u_host.irqCount;
            pins[pinIdx[i]] = 1'b1;
            cyc(5);
            rd(OFS_IFR, 8'(1 << i));
            check_cnt(u_host.irqCount, base);
            pins[pinIdx[i]] = 1'b0;
            wr(OFS_IFR, 8'hff);
            wr(OFS_IMR, 8'(1 << i));
            pins[pinIdx[i]] = 1'b1;
            cyc(5);
            pins[pinIdx[i]] = 1'b0;
            rd(OFS_IFR, 8'(1 << i));
            check_cnt(u_host.irqCount, base + 1);
            wr(OFS_IFR, 8'(1 << i));
            rd(OFS_IFR, 8'h00);
        end
        // current source gating, then low power refuses events
        wr(OFS_IMR, 8'h4f);
        wr(OFS_MUXCTL, {1'b1, LVL_40, 1'b0, SS_A0});
        check_val(8'(currentSourceOn), 8'h00);
        u_host.set_ps(1'b1);
        cyc(2);
        check_val(8'({busTxEnable, busPullupOn, currentSourceOn}), 8'h07);
        mode = MODE_STOP;
        base = u_host.irqCount;
        cyc(3);
        check_val(8'({busTxEnable, busPullupOn, currentSourceOn}), 8'h00);
        pins = adi_pins_type'(8'hf9);
        cyc(5);
        pins = adi_pins_type'(8'h01);
        cyc(5);
        rd(OFS_IFR, 8'h00);
        check_cnt(u_host.irqCount, base);
        mode = MODE_RUN;
        wr(OFS_MUXCTL, {1'b1, LVL_40, 1'b0, 4'h0});
        cyc(1);
        check_val(8'(currentSourceOn), 8'h00);
        // hall edges in each input mode
        for (int m = 0; m < 3; m++)
        begin
            hallMode = adi_hall_type'(m);
            for (int e = 0; e < 2; e++)
            begin
                pins.hallIn = !pins.hallIn;
                cyc(5);
                rd(OFS_IFR, (m == 2) ? 8'h00 : 8'h40);
                wr(OFS_IFR, 8'hff);
            end
        end
        // hall over-current flag, write one clears
        hallMode = HALL_2PIN;
        pins.hallOc = 1'b1;
        cyc(5);
        pins.hallOc = 1'b0;
        rd(OFS_HWSTAT, 8'h02);
        wr(OFS_HWSTAT, 8'h02);
        rd(OFS_HWSTAT, 8'h00);
        // wake input level and both edges in run
        wr(OFS_IMR, 8'h80);
        base = u_host.irqCount;
        pins.wakeIn = 1'b1;
        cyc(5);
        rd(OFS_HWSTAT, 8'h04);
        rd(OFS_IFR, 8'h80);
        wr(OFS_IFR, 8'hff);
        pins.wakeIn = 1'b0;
        cyc(5);
        rd(OFS_IFR, 8'h80);
        check_cnt(u_host.irqCount, base + 2);
        wr(OFS_IFR, 8'hff);
        // wake input change after entering stop, then sleep
        for (int s = 0; s < 2; s++)
        begin
            mode = s ? MODE_SLEEP : MODE_STOP;
            cyc(3);
            pins.wakeIn = !pins.wakeIn;
            cyc(6);
            check_cnt(nStop, 1);
            check_cnt(nReset, s);
            rd(s ? OFS_RSTAT : OFS_IFR, s ? 8'h01 : 8'h80);
            mode = MODE_RUN;
            wr(OFS_IFR, 8'hff);
        end
        // bus wake: short dominant, long in stop, long in sleep
        wr(OFS_IMR, 8'h20);
        for (int s = 0; s < 3; s++)
        begin
            mode = (s == 2) ? MODE_SLEEP : MODE_STOP;
            cyc(3);
            pins.busIn = 1'b0;
            cyc(s ? MIN_WAKE_CYC + 20 : 100);
            check_val(8'(busRxd), 8'h00);
            pins.busIn = 1'b1;
            cyc(6);
            check_val(8'(busRxd), 8'h01);
            check_cnt(nStop, s ? 2 : 1);
            check_cnt(nReset, s / 2 + 1);
            rd(s == 2 ? OFS_RSTAT : OFS_IFR, s == 0 ? 8'h00 : (s == 1 ? 8'h20 : 8'h02));
            mode = MODE_RUN;
            cyc(3);
        end
        report_and_stop();
    end
endmodule : adi_irq_wake_mux_bench
`default_nettype wire

// File: adi_pkg.sv
// adi_pkg: constants and types of the analog-die event, wake and mux block
// assumes one clock domain; register offsets are byte offsets of the die's register port
package adi_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_HWSTAT = 8'h07;  // hall / wake input status and control
    localparam logic [7:0] OFS_MUXCTL = 8'h08;  // analog select and current source
    localparam logic [7:0] OFS_IMR    = 8'h09;  // interrupt mask
    localparam logic [7:0] OFS_IFR    = 8'h0a;  // interrupt flags
    localparam logic [7:0] OFS_RSTAT  = 8'h0d;  // reset status

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int B_PSF  = 0;  // power stage fail
    localparam int B_HV   = 1;  // supply high
    localparam int B_LV   = 2;  // supply low
    localparam int B_HT   = 3;  // over temperature
    localparam int B_BUS  = 5;  // bus wake
    localparam int B_HALL = 6;  // hall input event
    localparam int B_WAKE = 7;  // wake input event
    localparam int B_HST  = 0;  // hall input state (status byte)
    localparam int B_HOC  = 1;  // hall over-current (status byte)
    localparam int B_WST  = 2;  // wake input state (status byte)
    localparam int B_RBUS = 1;  // bus wake reset bit (reset status)
    localparam int B_RWAK = 0;  // wake input reset bit (reset status)
    localparam int B_CSEN = 7;  // current source enable (MUXCTL)
    localparam int B_LVLH = 6;  // current level msb
    localparam int B_LVLL = 5;  // current level lsb
    localparam int B_GAIN = 4;  // half-bridge sense gain
    localparam int B_SSH  = 3;  // source select msb

    // ------------------------------------------------------------
    // reset values and codes
    // ------------------------------------------------------------
    localparam logic [7:0] RST_BYTE  = 8'h00;
    localparam logic [7:0] IRQ_MASK  = 8'hef;  // flag bits that exist in IFR
    localparam logic [3:0] SS_A0     = 4'h8;   // source select: analog input
    localparam logic [3:0] SS_CAL    = 4'h9;   // source select: calibration input
    // current level codes: 40, 120, 320, 800 microamp
    localparam logic [1:0] LVL_40    = 2'h0;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_NS        = 25;
    localparam int MIN_WAKE_NS   = 70000;  // min wake pulse time
    localparam int MIN_WAKE_CYC  = (MIN_WAKE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [11:0] WAKE_CNT = 12'(MIN_WAKE_CYC);

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {MODE_RUN, MODE_STOP, MODE_SLEEP} adi_mode_type;
    typedef enum logic [1:0] {HALL_GP, HALL_2PIN, HALL_3PIN} adi_hall_type;

    typedef struct packed {
        logic supplyHigh;  // supply-high comparator
        logic supplyLow;   // supply-low comparator
        logic overTemp;    // temperature above threshold
        logic stageFail;   // any power stage error
        logic hallIn;      // hall input state
        logic hallOc;      // hall input over-current
        logic wakeIn;      // wake input level
        logic busIn;       // bus level, 1 recessive
    } adi_pins_type;

    typedef struct packed {
        logic       wr;    // write strobe
        logic       rd;    // read strobe
        logic [7:0] addr;  // register offset
        logic [7:0] data;  // write data
    } adi_req_type;

endpackage : adi_pkg
